// *** src/isp_pkg.sv ***
package isp_pkg;

  // test access controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } tap_state_type;

  // flash operation sequencer states
  typedef enum logic [1:0] {OP_IDLE, OP_RUN, OP_ABORT} op_state_type;

  // instruction register
  localparam int          IR_W           = 8;
  localparam logic [7:0]  IR_CAPTURE     = 8'h01;
  localparam logic [7:0]  OPC_CH_ENABLE  = 8'h0c;
  localparam logic [7:0]  OPC_CH_DISABLE = 8'h0f;
  localparam logic [7:0]  OPC_ERR_CLEAR  = 8'h11;
  localparam logic [7:0]  OPC_PROGRAM    = 8'h21;
  localparam logic [7:0]  OPC_SECT_ERASE = 8'h22;
  localparam logic [7:0]  OPC_CHIP_ERASE = 8'h23;
  localparam logic [7:0]  OPC_READ       = 8'h24;
  localparam logic [7:0]  OPC_SECURE     = 8'h25;
  localparam logic [7:0]  OPC_BYPASS     = 8'hff;

  // data register layout: target, address, data
  localparam int DR_W       = 26;
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 16;
  localparam int TGT_W      = 2;
  localparam int DR_DATA_LSB = 0;
  localparam int DR_ADDR_LSB = 8;
  localparam int DR_TGT_LSB  = 24;
  localparam int SECT_W      = 3;
  localparam int SECT_LSB    = 13;
  localparam int NUM_SECT    = 8;

  // channel-enable option bits in the data register
  localparam int OPT_STAT_EN = 0;
  localparam int OPT_ERR_EN  = 1;
  localparam int OPT_OPEN_DR = 2;

  // fill value of an erased or blank location
  localparam logic [7:0] BLANK_BYTE = 8'hff;

  // flash operation codes
  localparam logic [1:0] FOP_PROG   = 2'h0;
  localparam logic [1:0] FOP_SERASE = 2'h1;
  localparam logic [1:0] FOP_CERASE = 2'h2;

  // register port
  localparam int         REG_AW       = 4;
  localparam int         REG_DW       = 8;
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_CLR  = 4'h8;
  localparam logic [3:0] REG_IRQ_EN   = 4'hc;

  // event bits
  localparam int EV_W       = 4;
  localparam int EV_DONE    = 0;
  localparam int EV_ERROR   = 1;
  localparam int EV_CHANNEL = 2;
  localparam int EV_REFUSED = 3;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int ABORT_CNT_W   = 16;

endpackage

// *** src/isp_sync.sv ***
module isp_sync
  import isp_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // two flops per pin; first stage only feeds the second
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// *** src/isp_tap.sv ***
module isp_tap
  import isp_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    rstn,
  input  wire logic    tckRise,
  input  wire logic    tms,
  output tap_state_type tapState
);

  tap_state_type state_q;
  tap_state_type state_d;

  // standard controller transitions
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      TAP_RESET:  state_d = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:   state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  state_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: state_d = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  state_d = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: state_d = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_d = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  state_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: state_d = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  state_d = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: state_d = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    state_d = TAP_RESET;
    endcase
  end

  // advance only on a rising test clock
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= TAP_RESET;
    else if (tckRise)
      state_q <= state_d; // [R17]
  end

  assign tapState = state_q;

endmodule

// *** src/jtag_isp_program_port.sv ***
// Notes on behaviour
// [R01] blank part: four test pins on port
// [R02] pins inputs until enable; then data out
// [R03] enable command may enable status/error pins
// [R04] enable command may select open-drain extensions
// [R05] error pin low on failed erase/program
// [R06] error held until clear, or reset-after-disable
// [R07] status pin high while flash readable
// [R08] status pin low during program/erase
// [R09] system holds device reset during programming
// [R10] configuration commands only, no boundary scan
// [R11] secured: no reads, only chip erase
// [R12] chip erase clears the security bit
// [R13] protected sectors refuse erasure; only sector erase is refused, chip erase still runs
// [R14] reset aborts flash cycle, back to read
// [R15] programs arrays, logic and configuration bits
// [R16] blank content reads as all ones
// [R17] standard controller; sample rising, drive falling
//
// The register addresses and the plain strobed port were chosen for this implementation.
module jtag_isp_program_port
  import isp_pkg::*;
#(
  parameter int RESET_ABORT_TIME_NS = 1000
)(
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                tckPin,
  input  wire logic                tmsPin,
  input  wire logic                tdiPin,
  output logic                     tdoOut,
  output logic                     tdoOe,
  output logic                     statOut,
  output logic                     statOe,
  output logic                     errOut,
  output logic                     errOe,
  input  wire logic                devResetN,
  input  wire logic                secureCfg,
  input  wire logic [NUM_SECT-1:0] sectorProtect,
  output logic                     flashStart,
  output logic      [1:0]          flashOp,
  output logic      [TGT_W-1:0]    flashTarget,
  output logic      [ADDR_W-1:0]   flashAddr,
  output logic      [DATA_W-1:0]   flashData,
  output logic                     flashAbort,
  input  wire logic [DATA_W-1:0]   flashRdData,
  input  wire logic                flashDone,
  input  wire logic                flashFail,
  input  wire logic                flashBusy,
  input  wire logic [REG_AW-1:0]   regAddr,
  input  wire logic [REG_DW-1:0]   regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [REG_DW-1:0]   regRdata,
  output logic                     irq
);

  // longest time: round down, never below one cycle
  localparam int ABORT_RAW = RESET_ABORT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [ABORT_CNT_W-1:0] ABORT_CYC = ABORT_CNT_W'((ABORT_RAW < 1) ? 1 : ABORT_RAW);

  // sector number of a flash address
  function automatic logic [SECT_W-1:0] sectorOf(input logic [ADDR_W-1:0] a);
    sectorOf = a[SECT_LSB +: SECT_W];
  endfunction

  logic                   tckS;
  logic                   tmsS;
  logic                   tdiS;
  logic                   devRstNS;
  logic                   tckPrev_q;
  logic                   devRstPrev_q;
  tap_state_type          tapState;
  logic [IR_W-1:0]        irSh_q;
  logic [IR_W-1:0]        irAct_q;
  logic [DR_W-1:0]        drSh_q;
  logic                   byp_q;
  logic                   tdo_q;
  logic                   chEn_q;
  logic [2:0]             opts_q;
  logic                   disSeen_q;
  logic                   secure_q;
  logic                   loaded_q;
  logic                   errFlag_q;
  op_state_type           opState_q;
  logic [ABORT_CNT_W-1:0] abortCnt_q;
  logic                   start_q;
  logic [1:0]             fop_q;
  logic [TGT_W-1:0]       tgt_q;
  logic [ADDR_W-1:0]      addr_q;
  logic [DATA_W-1:0]      data_q;
  logic                   statPin_q;
  logic                   errPin_q;
  logic [EV_W-1:0]        irqStat_q;
  logic [EV_W-1:0]        irqEn_q;
  logic [REG_DW-1:0]      rdata_q;

  // pins pass two flops before use
  isp_sync #(
    .WIDTH (4)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     ({tckPin, tmsPin, tdiPin, devResetN}),
    .dout    ({tckS, tmsS, tdiS, devRstNS})
  );

  // test clock and device reset edges
  wire tckRise  = tckS & ~tckPrev_q;
  wire tckFall  = ~tckS & tckPrev_q;
  wire devRstIn = ~devRstNS & devRstPrev_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tckPrev_q    <= 1'b0;
      devRstPrev_q <= 1'b0;
    end
    else
    begin
      tckPrev_q    <= tckS;
      devRstPrev_q <= devRstNS;
    end
  end

  isp_tap u_tap (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .tckRise  (tckRise),
    .tms      (tmsS),
    .tapState (tapState)
  );

  // instruction decode; unknown codes fall to bypass
  wire isEnable  = irAct_q == OPC_CH_ENABLE;
  wire isDisable = irAct_q == OPC_CH_DISABLE;
  wire isClear   = irAct_q == OPC_ERR_CLEAR;
  wire isProg    = irAct_q == OPC_PROGRAM;
  wire isSErase  = irAct_q == OPC_SECT_ERASE;
  wire isCErase  = irAct_q == OPC_CHIP_ERASE;
  wire isRead    = irAct_q == OPC_READ;
  wire isSecure  = irAct_q == OPC_SECURE;
  wire isFlashOp = isProg | isSErase | isCErase;
  wire selBypass = ~(isEnable | isDisable | isClear | isFlashOp | isRead | isSecure); // [R10]

  wire updDr = tckFall & (tapState == TAP_UPD_DR);
  wire updIr = tckFall & (tapState == TAP_UPD_IR);
  wire cmdOk = updDr & chEn_q;

  // fields of the shifted data word
  wire [ADDR_W-1:0] drAddr = drSh_q[DR_ADDR_LSB +: ADDR_W];
  wire [DATA_W-1:0] drData = drSh_q[DR_DATA_LSB +: DATA_W];
  wire [TGT_W-1:0]  drTgt  = drSh_q[DR_TGT_LSB +: TGT_W];

  // refusal: security, protection, sequencer busy
  wire secBlock  = secure_q & (isProg | isSErase | isRead | isSecure); // [R11]
  wire protBlock = isSErase & sectorProtect[sectorOf(drAddr)]; // [R13]
  wire busyBlock = isFlashOp & (opState_q != OP_IDLE);
  wire refuse    = cmdOk & (secBlock | protBlock | busyBlock);
  wire launch    = cmdOk & isFlashOp & ~(secBlock | protBlock | busyBlock);
  wire secureCmd = cmdOk & isSecure & ~secure_q;
  wire readCmd   = cmdOk & isRead & ~secure_q;

  // read capture hides contents when secured
  wire [DATA_W-1:0] rdView = secure_q ? '0 : flashRdData; // [R11]

  // instruction shift and update
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irSh_q  <= IR_CAPTURE;
      irAct_q <= OPC_BYPASS;
    end
    else if (tckRise && tapState == TAP_RESET)
      irAct_q <= OPC_BYPASS;
    else if (tckRise && tapState == TAP_CAP_IR)
      irSh_q <= IR_CAPTURE;
    else if (tckRise && tapState == TAP_SH_IR)
      irSh_q <= {tdiS, irSh_q[IR_W-1:1]}; // [R17]
    else if (updIr)
      irAct_q <= irSh_q;
  end

  // data and bypass shift; capture returns the read view
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drSh_q <= '0;
      byp_q  <= 1'b0;
    end
    else if (tckRise && tapState == TAP_CAP_DR)
    begin
      drSh_q <= {tgt_q, addr_q, rdView};
      byp_q  <= 1'b0;
    end
    else if (tckRise && tapState == TAP_SH_DR)
    begin
      drSh_q <= {tdiS, drSh_q[DR_W-1:1]}; // [R17]
      byp_q  <= tdiS;
    end
  end

  // serial output moves on the falling test clock
  wire shifting = (tapState == TAP_SH_IR) | (tapState == TAP_SH_DR);
  wire tdoNext  = (tapState == TAP_SH_IR) ? irSh_q[0] : (selBypass ? byp_q : drSh_q[0]);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      tdo_q <= 1'b0;
    else if (tckFall)
      tdo_q <= tdoNext; // [R17]
  end

  // channel enable, options and disable history
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chEn_q    <= 1'b0; // [R02]
      opts_q    <= '0;
      disSeen_q <= 1'b0;
    end
    else if (updDr && isEnable)
    begin
      chEn_q    <= 1'b1; // [R02]
      opts_q    <= drSh_q[OPT_OPEN_DR:OPT_STAT_EN]; // [R03] [R04]
      disSeen_q <= 1'b0;
    end
    else if (cmdOk && isDisable)
    begin
      chEn_q    <= 1'b0;
      disSeen_q <= 1'b1;
    end
    else if (devRstIn)
      disSeen_q <= 1'b0;
  end

  // security bit: loaded once after reset release
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      secure_q <= 1'b0;
      loaded_q <= 1'b0;
    end
    else if (!loaded_q)
    begin
      secure_q <= secureCfg;
      loaded_q <= 1'b1;
    end
    else if (opState_q == OP_RUN && flashDone && !flashFail && fop_q == FOP_CERASE)
      secure_q <= 1'b0; // [R12]
    else if (secureCmd)
      secure_q <= 1'b1;
  end

  // error flag: failure wins over clear
  wire errSet = (opState_q == OP_RUN) & flashDone & flashFail; // [R05]
  wire errClr = (cmdOk & isClear) | (devRstIn & disSeen_q); // [R06]

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      errFlag_q <= 1'b0;
    else
      errFlag_q <= errSet | (errFlag_q & ~errClr); // [R06]
  end

  // operation parameters latched on launch or on a read command
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fop_q  <= FOP_PROG;
      tgt_q  <= '0;
      addr_q <= '0;
      data_q <= BLANK_BYTE;
    end
    else if (launch || readCmd)
    begin
      fop_q  <= isProg ? FOP_PROG : (isSErase ? FOP_SERASE : FOP_CERASE);
      tgt_q  <= drTgt; // [R15]
      addr_q <= drAddr;
      data_q <= isProg ? drData : BLANK_BYTE; // [R16]
    end
  end

  // flash sequencer with reset abort
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      opState_q  <= OP_IDLE;
      abortCnt_q <= '0;
      start_q    <= 1'b0;
    end
    else
    begin
      start_q <= launch;
      case (opState_q)
        OP_IDLE:
        begin
          if (launch)
            opState_q <= OP_RUN;
        end
        OP_RUN:
        begin
          if (devRstIn)
          begin
            opState_q  <= OP_ABORT; // [R14]
            abortCnt_q <= ABORT_CYC;
          end
          else if (flashDone)
            opState_q <= OP_IDLE;
        end
        OP_ABORT:
        begin
          abortCnt_q <= abortCnt_q - 1'b1;
          if (abortCnt_q == ABORT_CNT_W'(1))
            opState_q <= OP_IDLE; // [R14]
        end
        default: opState_q <= OP_IDLE;
      endcase
    end
  end

  // extension pin levels from flops
  wire readMode = (opState_q == OP_IDLE) & ~flashBusy & ~start_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      statPin_q <= 1'b1;
      errPin_q  <= 1'b1;
    end
    else
    begin
      statPin_q <= readMode; // [R07] [R08]
      errPin_q  <= ~errFlag_q; // [R05]
    end
  end

  // pin drivers: dedicated port pins, released until enabled
  wire statEn = chEn_q & opts_q[OPT_STAT_EN];
  wire errEn  = chEn_q & opts_q[OPT_ERR_EN];
  wire od     = opts_q[OPT_OPEN_DR];

  assign tdoOut  = tdo_q; // [R01]
  assign tdoOe   = chEn_q & shifting; // [R02]
  assign statOut = statPin_q;
  assign statOe  = statEn & (~od | ~statPin_q); // [R03] [R04]
  assign errOut  = errPin_q;
  assign errOe   = errEn & (~od | ~errPin_q); // [R04]

  assign flashStart  = start_q;
  assign flashOp     = fop_q;
  assign flashTarget = tgt_q;
  assign flashAddr   = addr_q;
  assign flashData   = data_q;
  assign flashAbort  = opState_q == OP_ABORT; // [R14]

  // events into sticky status; set wins over clear
  wire [EV_W-1:0] events;
  assign events[EV_DONE]    = (opState_q == OP_RUN) & flashDone & ~devRstIn;
  assign events[EV_ERROR]   = errSet & ~devRstIn;
  assign events[EV_CHANNEL] = (updDr & isEnable) | (cmdOk & isDisable);
  assign events[EV_REFUSED] = refuse;

  wire wrClr = regWr & (regAddr == REG_IRQ_CLR);
  wire wrEn  = regWr & (regAddr == REG_IRQ_EN);
  wire [EV_W-1:0] clrMask = wrClr ? regWdata[EV_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irqStat_q <= '0;
      irqEn_q   <= '0;
    end
    else
    begin
      irqStat_q <= events | (irqStat_q & ~clrMask);
      if (wrEn)
        irqEn_q <= regWdata[EV_W-1:0];
    end
  end

  assign irq = |(irqStat_q & irqEn_q);

  // read mux; clear register and unmapped read zero
  wire [REG_DW-1:0] ctrlView = {1'b0, secure_q, errFlag_q, ~readMode, chEn_q, opts_q};
  wire [REG_DW-1:0] rdMux =
    (regAddr == REG_CTRL)     ? ctrlView :
    (regAddr == REG_IRQ_STAT) ? {{(REG_DW-EV_W){1'b0}}, irqStat_q} :
    (regAddr == REG_IRQ_EN)   ? {{(REG_DW-EV_W){1'b0}}, irqEn_q} : '0;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= '0;
    else if (regRd)
      rdata_q <= rdMux;
    else
      rdata_q <= '0;
  end

  assign regRdata = rdata_q;

endmodule

// *** tb/jtag_isp_program_port_asserts.sv ***
module jtag_isp_program_port_asserts
  import isp_pkg::*;
#(
  parameter int RESET_ABORT_TIME_NS = 1000
)(
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                tckPin,
  input wire logic                tdoOut,
  input wire logic                statOut,
  input wire logic                errOut,
  input wire logic                secureCfg,
  input wire logic [NUM_SECT-1:0] sectorProtect,
  input wire logic                flashStart,
  input wire logic [1:0]          flashOp,
  input wire logic [ADDR_W-1:0]   flashAddr,
  input wire logic [DATA_W-1:0]   flashData,
  input wire logic                flashAbort,
  input wire logic                flashDone,
  input wire logic                flashFail,
  input wire logic                flashBusy,
  input wire logic                regRd,
  input wire logic [REG_DW-1:0]   regRdata
);
  localparam int ABORT_CYC = RESET_ABORT_TIME_NS / CLK_PERIOD_NS;
  logic [15:0] abortCnt_q;

  // length of the current abort run
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      abortCnt_q <= 16'h0;
    else
      abortCnt_q <= flashAbort ? abortCnt_q + 16'h1 : 16'h0;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_start_pulse: assert property (flashStart |=> !flashStart)
    else $error("start pulse too long");
  a_erase_blank: assert property (flashStart && flashOp != FOP_PROG |-> flashData == BLANK_BYTE)
    else $error("erase fill not blank");
  a_start_stat: assert property (flashStart |-> ##[0:2] !statOut)
    else $error("status high after op start");
  a_busy_stat: assert property (flashBusy |-> ##[0:3] !statOut)
    else $error("status high while flash busy");
  a_done_stat: assert property (flashDone |-> ##[1:3] statOut)
    else $error("status not high after done");
  a_fail_err: assert property (flashDone && flashFail |-> ##2 !errOut)
    else $error("error pin not low after failure");
  a_abort_len: assert property (abortCnt_q <= ABORT_CYC)
    else $error("abort longer than allowed");
  a_tdo_fall: assert property ($changed(tdoOut) |-> !tckPin)
    else $error("data out moved while clock high");
  a_rd_idle: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside read answer");
  a_secure_op: assert property (secureCfg && flashStart |-> flashOp == FOP_CERASE)
    else $error("secured op not chip erase");
  a_protect_sect: assert property (flashStart && flashOp == FOP_SERASE |-> !sectorProtect[flashAddr[15:13]])
    else $error("protected sector erased");

  c_fail: cover property (flashDone && flashFail);
  c_abort: cover property (flashAbort);
  c_chip: cover property (flashStart && flashOp == FOP_CERASE);
endmodule

// *** tb/flash_array_model.sv ***
module flash_array_model
  import isp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              flashStart,
  input  wire logic [1:0]        flashOp,
  input  wire logic [TGT_W-1:0]  flashTarget,
  input  wire logic [ADDR_W-1:0] flashAddr,
  input  wire logic [DATA_W-1:0] flashData,
  input  wire logic              flashAbort,
  input  wire logic              failReq,
  input  wire logic              slowOp,
  output logic      [DATA_W-1:0] flashRdData,
  output logic                   flashDone,
  output logic                   flashFail,
  output logic                   flashBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [logic [17:0]];
  logic [27:0] req;
  int          cnt;

  function automatic logic [7:0] rdByte(input logic [17:0] k);
    return mem.exists(k) ? mem[k] : BLANK_BYTE;
  endfunction
  assign flashRdData = rdByte({flashTarget, flashAddr});

  // one op at a time, done pulse 40 cycles after start, or 300 with slowOp
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flashBusy <= 1'b0;
      flashDone <= 1'b0;
      flashFail <= 1'b0;
    end
    else
    begin
      flashDone <= 1'b0;
      flashFail <= 1'b0;
      if (flashAbort)
        flashBusy <= 1'b0;
      else if (flashStart)
      begin
        flashBusy <= 1'b1;
        cnt <= slowOp ? 300 : 40;
        req <= {flashOp, flashTarget, flashAddr, flashData};
      end
      else if (flashBusy)
      begin
        cnt <= cnt - 1;
        if (cnt == 1)
        begin
          flashBusy <= 1'b0;
          flashDone <= 1'b1;
          flashFail <= failReq;
          if (req[27:26] == FOP_CERASE)
            mem.delete();
          else if (req[27:26] == FOP_PROG && !failReq)
            mem[req[25:8]] = rdByte(req[25:8]) & req[7:0];
        end
      end
    end
  end
endmodule

// *** tb/test_jtag_isp_program_port.sv ***
module test_jtag_isp_program_port
  import isp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, rstn = 1'b0, tckPin = 1'b0, tmsPin = 1'b0, tdiPin = 1'b0;
  logic        devResetN = 1'b0, secureCfg = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic        failReq = 1'b0, slowOp = 1'b0;
  logic [7:0]  sectorProtect = 8'h00, regWdata = 8'h00, d, lastIr, flashRdData, flashData;
  logic [3:0]  regAddr = 4'h0;
  logic        tdoOut, tdoOe, statOut, statOe, errOut, errOe, flashStart, flashAbort, irq;
  logic        flashDone, flashFail, flashBusy, oeSeen, lowSeen, abortSeen;
  logic [1:0]  flashOp, flashTarget;
  logic [15:0] flashAddr;
  logic [7:0]  regRdata;
  logic [25:0] o;
  logic [27:0] lastReq;
  int          nFail = 0, totalChecks = 0, cyc = 0, startCnt = 0, n0;

  always #2.5 sys_clk = ~sys_clk;

  jtag_isp_program_port #(.RESET_ABORT_TIME_NS(100)) dut_u (.sys_clk, .rstn, .tckPin, .tmsPin, .tdiPin,
    .tdoOut, .tdoOe, .statOut, .statOe, .errOut, .errOe, .devResetN, .secureCfg, .sectorProtect,
    .flashStart, .flashOp, .flashTarget, .flashAddr, .flashData, .flashAbort, .flashRdData, .flashDone,
    .flashFail, .flashBusy, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq);

  flash_array_model flash_u (.sys_clk, .rstn, .flashStart, .flashOp, .flashTarget, .flashAddr, .flashData,
    .flashAbort, .failReq, .slowOp, .flashRdData, .flashDone, .flashFail, .flashBusy);

  // watchers and hang limit
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (flashStart) startCnt <= startCnt + 1;
    if (flashStart) lastReq <= {flashOp, flashTarget, flashAddr, flashData};
    if (tdoOe) oeSeen <= 1'b1;
    if (!statOut) lowSeen <= 1'b1;
    if (flashAbort) abortSeen <= 1'b1;
    if (cyc == 80000)
    begin
      nFail++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one test clock period, data out taken before the rising edge
  task automatic tck1(input logic m, input logic v, output logic b);
    @(posedge sys_clk);
    tmsPin <= m;
    tdiPin <= v;
    repeat (4) @(posedge sys_clk);
    b = tdoOut;
    tckPin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    tckPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic scan(input logic ir, input logic [25:0] v, input int n, output logic [25:0] q);
    logic b;
    q = '0;
    tck1(1'b1, 1'b0, b);
    if (ir) tck1(1'b1, 1'b0, b);
    tck1(1'b0, 1'b0, b);
    tck1(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      tck1(i == n - 1, v[i], b);
      q[i] = b;
    end
    tck1(1'b1, 1'b0, b);
    tck1(1'b0, 1'b0, b);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [25:0] dr);
    logic [25:0] q;
    scan(1'b1, {18'h0, op}, IR_W, q);
    lastIr = q[7:0];
    scan(1'b0, dr, DR_W, o);
  endtask

  task automatic readByte(input logic [15:0] a);
    cmd(OPC_READ, {2'h0, a, 8'h00});
    scan(1'b0, 26'h0, DR_W, o);
  endtask

  task automatic tapReset();
    logic b;
    repeat (5) tck1(1'b1, 1'b0, b);
    tck1(1'b0, 1'b0, b);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic waitIdle();
    for (int k = 0; k < 500 && (flashBusy || !statOut); k++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    // device reset stays asserted while programming, released only to start the abort-test sector erase
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk({statOut, errOut, tdoOe, statOe, errOe, irq}, 6'b110000);
    tapReset();
    oeSeen <= 1'b0;
    cmd(OPC_CH_ENABLE, 26'h3);
    chk(oeSeen, 1'b0);
    chk({statOe, errOe}, 2'b11);
    rd(REG_CTRL);
    chk(d, 8'h0b);
    wr(REG_IRQ_EN, 8'h0f);
    rd(REG_IRQ_EN);
    chk(d, 8'h0f);
    rd(REG_IRQ_STAT);
    chk({d, irq}, {8'h04, 1'b1});
    wr(REG_IRQ_STAT, 8'h00);
    wr(REG_IRQ_CLR, 8'h0f);
    rd(REG_IRQ_STAT);
    chk({d, irq}, 9'h0);
    rd(4'h2);
    chk(d, 8'h00);
    $display("test enable and registers done");
    lowSeen <= 1'b0;
    n0 = startCnt;
    for (int t = 0; t < 4; t++)
    begin
      cmd(OPC_PROGRAM, {t[1:0], 16'h1234, 8'h5a ^ 8'(t)});
      waitIdle();
      chk(lastReq, {FOP_PROG, t[1:0], 16'h1234, 8'h5a ^ 8'(t)});
    end
    chk({lastIr, oeSeen, lowSeen, statOut}, {IR_CAPTURE, 3'b111});
    chk(startCnt - n0, 4);
    readByte(16'h1234);
    chk(o[7:0], 8'h5a);
    readByte(16'h0100);
    chk(o[7:0], BLANK_BYTE);
    $display("test program and read done");
    failReq <= 1'b1;
    cmd(OPC_PROGRAM, {2'h0, 16'h0200, 8'h00});
    waitIdle();
    failReq <= 1'b0;
    chk({errOut, irq}, 2'b01);
    sectorProtect <= 8'h02;
    n0 = startCnt;
    cmd(OPC_SECT_ERASE, {2'h0, 16'h2000, 8'h00});
    waitIdle();
    rd(REG_IRQ_STAT);
    chk({startCnt - n0, d[3], errOut}, 2'b10);
    cmd(OPC_ERR_CLEAR, 26'h0);
    chk(errOut, 1'b1);
    wr(REG_IRQ_CLR, 8'h0f);
    $display("test error and protect done");
    devResetN <= 1'b1;
    slowOp <= 1'b1;
    cmd(OPC_SECT_ERASE, {2'h0, 16'h4000, 8'h00});
    chk({lastReq[27:26], flashBusy}, {FOP_SERASE, 1'b1});
    abortSeen <= 1'b0;
    devResetN <= 1'b0;
    for (int k = 0; k < 100 && !statOut; k++) @(posedge sys_clk);
    slowOp <= 1'b0;
    chk({abortSeen, statOut}, 2'b11);
    cmd(OPC_CH_ENABLE, 26'h7);
    waitIdle();
    chk({statOe, errOe}, 2'b00);
    $display("test abort and open drain done");
    secureCfg <= 1'b1;
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    tapReset();
    cmd(OPC_CH_ENABLE, 26'h3);
    n0 = startCnt;
    cmd(OPC_PROGRAM, {2'h0, 16'h0300, 8'h00});
    waitIdle();
    readByte(16'h1234);
    chk({startCnt - n0, o[7:0]}, 9'h0);
    cmd(OPC_CHIP_ERASE, 26'h0);
    waitIdle();
    secureCfg <= 1'b0;
    chk({lastReq[27:26], 8'(startCnt - n0)}, {FOP_CERASE, 8'h01});
    readByte(16'h1234);
    chk(o[7:0], BLANK_BYTE);
    cmd(OPC_SECURE, 26'h0);
    readByte(16'h1234);
    chk(o[7:0], 8'h00);
    $display("test security done");
    summarize();
  end
endmodule

bind jtag_isp_program_port jtag_isp_program_port_asserts #(.RESET_ABORT_TIME_NS(RESET_ABORT_TIME_NS)) chk_u (
  .sys_clk, .rstn, .tckPin, .tdoOut, .statOut, .errOut, .secureCfg, .sectorProtect, .flashStart, .flashOp,
  .flashAddr, .flashData, .flashAbort, .flashDone, .flashFail, .flashBusy, .regRd, .regRdata);
